// ==== rtl/keyboard_matrix_encoder.sv ====
// Keyboard matrix encoder: scan rings, comparator, code output, AHB-Lite registers
//
// Contract
// - Eight and eleven stage rings, eleven-bit comparator
// - 264x9 table, three groups by shift/control
// - Table address from group and ring states
// - No key: rings keep stepping, scanning
// - Strobe inactive while scanning without key
// - Match when the sense line picked by the sense ring is high
// - Match stops clock directly, strobe via delay
// - On match stop rings, present code, strobe
// - Code stays fixed while key held
// - Parity invert selects parity output polarity
// - Data invert flips data bits and strobe
// - Each word: eight code bits plus parity
// - Strobe delayed by adjustable debounce interval
// - Second key cannot corrupt presented code
`default_nettype none
`include "kbd_defs.svh"
module keyboard_matrix_encoder #(
  parameter logic [15:0] DEBOUNCE_CYCLES = 16'(`KBD_DEBOUNCE_CYCLES)
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [`KBD_DRIVE_STAGES-1:0]  scan_drive_lines,
  input  wire logic [`KBD_SENSE_STAGES-1:0]  scan_sense_lines,
  input  wire logic                          shift_key,
  input  wire logic                          control_key,
  output logic      [`KBD_CODE_W-1:0]        key_code_out,
  output logic                               key_strobe
);

  typedef struct packed {
    kbd_pkg::scan_state_t             state;
    logic [`KBD_DRIVE_STAGES-1:0]     drive_ring;
    logic [`KBD_SENSE_STAGES-1:0]     sense_ring;
    logic [1:0]                       settle;
    logic [`KBD_SENSE_STAGES-1:0]     sense_meta;
    logic [`KBD_SENSE_STAGES-1:0]     sense_sync;
    logic [1:0]                       mod_meta;
    logic [1:0]                       mod_sync;
    logic [`KBD_CODE_W-1:0]           held_code;
    logic                             valid;
    logic [`KBD_CODE_W-1:0]           code_pin;
    logic                             strobe_pin;
    logic                             parity_invert;
    logic                             data_invert;
    logic [15:0]                      debounce_load;
    logic                             wr_pend;
    logic [7:0]                       wr_addr;
    logic [31:0]                      rdata;
    logic                             ready;
    logic                             resp;
  } enc_state_t;

  enc_state_t st;
  enc_state_t next_st;

  logic [`KBD_ADDR_W-1:0] table_addr;
  logic [`KBD_CODE_W-1:0] table_data;
  logic                   match;
  logic                   bounce_start;
  logic                   bounce_cancel;
  logic                   bounce_done;
  logic [1:0]             group;
  logic                   addr_phase;

  code_table u_table (
    .hclk    (hclk),
    .hresetn (hresetn),
    .addr    (table_addr),
    .rd_data (table_data)
  );

  debounce_timer u_bounce (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (bounce_start),
    .cancel  (bounce_cancel),
    .load    (st.debounce_load),
    .expired (bounce_done)
  );

  function automatic logic [31:0] status_word(input enc_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`KBD_STAT_STROBE] = s.valid;
    w[`KBD_STAT_STATE_LSB +: 2] = s.state;
    w[`KBD_STAT_CODE_LSB +: `KBD_CODE_W] = s.held_code;
    w[`KBD_STAT_DRIVE_LSB +: 4] = kbd_pkg::onehot_index(16'(s.drive_ring));
    w[`KBD_STAT_SENSE_LSB +: 4] = kbd_pkg::onehot_index(16'(s.sense_ring));
    return w;
  endfunction

  always_comb begin
    // Control wins over shift when both are held
    if (st.mod_sync[1]) begin
      group = `KBD_GROUP_CONTROL;
    end else if (st.mod_sync[0]) begin
      group = `KBD_GROUP_SHIFT;
    end else begin
      group = `KBD_GROUP_PLAIN;
    end
    table_addr = `KBD_ADDR_W'(group * `KBD_GROUP_WORDS
               + kbd_pkg::onehot_index(16'(st.drive_ring)) * `KBD_SENSE_STAGES
               + kbd_pkg::onehot_index(16'(st.sense_ring)));
    // Stale sense data from the previous drive line is masked by settle
    match = (st.settle == 2'h0) && |(st.sense_sync & st.sense_ring);
  end

  always_comb begin
    next_st       = st;
    bounce_start  = 1'b0;
    bounce_cancel = 1'b0;
    addr_phase    = hsel && htrans[1] && hready;

    next_st.sense_meta = scan_sense_lines;
    next_st.sense_sync = st.sense_meta;
    next_st.mod_meta   = {control_key, shift_key};
    next_st.mod_sync   = st.mod_meta;

    case (st.state)
      kbd_pkg::SCAN: begin
        if (match) begin
          // Comparator halts the rings at once; strobe waits for the delay
          next_st.state = kbd_pkg::BOUNCE;
          bounce_start  = 1'b1;
        end else if (st.settle != 2'h0) begin
          next_st.settle = st.settle - 2'h1;
        end else if (st.sense_ring[`KBD_SENSE_STAGES-1]) begin
          next_st.sense_ring = `KBD_SENSE_STAGES'(1);
          next_st.drive_ring = {st.drive_ring[`KBD_DRIVE_STAGES-2:0],
                                st.drive_ring[`KBD_DRIVE_STAGES-1]};
          next_st.settle     = `KBD_SETTLE_CYCLES;
        end else begin
          next_st.sense_ring = {st.sense_ring[`KBD_SENSE_STAGES-2:0], 1'b0};
        end
      end
      kbd_pkg::BOUNCE: begin
        if (!match) begin
          bounce_cancel = 1'b1;
          next_st.state = kbd_pkg::SCAN;
        end else if (bounce_done) begin
          next_st.held_code = table_data;
          next_st.valid     = 1'b1;
          next_st.state     = kbd_pkg::HOLD;
          bounce_cancel     = 1'b1;
        end
      end
      kbd_pkg::HOLD: begin
        // Rings stay frozen, so other keys are not seen until release
        if (!match) begin
          next_st.valid = 1'b0;
          next_st.state = kbd_pkg::SCAN;
        end
      end
      default: begin
        next_st.state = kbd_pkg::SCAN;
      end
    endcase

    // Data outputs follow the held code and the inversion bits; the code changes on a new key only
    next_st.code_pin = {st.held_code[`KBD_PARITY_BIT] ^ st.parity_invert,
                        st.held_code[7:0] ^ {8{st.data_invert}}};
    next_st.strobe_pin = st.valid ^ st.data_invert;

    if (st.wr_pend && st.wr_addr == `KBD_REG_CTRL) begin
      next_st.parity_invert = hwdata[`KBD_CTRL_PAR_INV];
      next_st.data_invert   = hwdata[`KBD_CTRL_DAT_INV];
      next_st.debounce_load = hwdata[`KBD_CTRL_DEB_LSB +: 16];
    end
    next_st.wr_pend = addr_phase && hwrite;
    next_st.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite) begin
      if (haddr[31:0] == 32'(`KBD_REG_CTRL)) begin
        next_st.rdata = {st.debounce_load, 14'h0000, st.data_invert, st.parity_invert};
      end else if (haddr[31:0] == 32'(`KBD_REG_STATUS)) begin
        next_st.rdata = status_word(st);
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
    if (!(addr_phase && haddr[31:8] == 24'h00_0000)) begin
      next_st.wr_pend = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st               <= '0;
      st.state         <= kbd_pkg::SCAN;
      st.drive_ring    <= `KBD_DRIVE_STAGES'(1);
      st.sense_ring    <= `KBD_SENSE_STAGES'(1);
      st.settle        <= `KBD_SETTLE_CYCLES;
      st.debounce_load <= DEBOUNCE_CYCLES;
      // Zero wait states: ready stands high from reset on, response stays OKAY
      st.ready         <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata           = st.rdata;
  assign hreadyout        = st.ready;
  assign hresp            = st.resp;
  assign scan_drive_lines = st.drive_ring;
  assign key_code_out     = st.code_pin;
  assign key_strobe       = st.strobe_pin;

endmodule // keyboard_matrix_encoder
`default_nettype wire

// ==== rtl/kbd_defs.svh ====
// Constants for the keyboard matrix encoder: sizes, timing, register map
`ifndef KBD_DEFS_SVH
`define KBD_DEFS_SVH

`define KBD_DRIVE_STAGES    8
`define KBD_SENSE_STAGES    11
`define KBD_GROUP_WORDS     88
`define KBD_TABLE_WORDS     264
`define KBD_ADDR_W          9
`define KBD_CODE_W          9
`define KBD_PARITY_BIT      8
`define KBD_SETTLE_CYCLES   2'h2

`define KBD_GROUP_PLAIN     2'h0
`define KBD_GROUP_SHIFT     2'h1
`define KBD_GROUP_CONTROL   2'h2

`define KBD_CLK_MHZ         25
`define KBD_DEBOUNCE_US     1500
`define KBD_DEBOUNCE_CYCLES (`KBD_DEBOUNCE_US * `KBD_CLK_MHZ)
`define KBD_DEBOUNCE_MIN    16'h0002

`define KBD_REG_CTRL        8'h00
`define KBD_REG_STATUS      8'h04
`define KBD_CTRL_PAR_INV    0
`define KBD_CTRL_DAT_INV    1
`define KBD_CTRL_DEB_LSB    16
`define KBD_CTRL_RESET      32'h0000_0000

`define KBD_STAT_STROBE     0
`define KBD_STAT_STATE_LSB  1
`define KBD_STAT_CODE_LSB   4
`define KBD_STAT_DRIVE_LSB  16
`define KBD_STAT_SENSE_LSB  20

`endif

// ==== rtl/kbd_pkg.sv ====
// Types and shared helpers of the keyboard matrix encoder
`default_nettype none
package kbd_pkg;

  typedef enum logic [1:0] {
    SCAN,
    BOUNCE,
    HOLD
  } scan_state_t;

  function automatic logic [3:0] onehot_index(input logic [15:0] ring);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (ring[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

endpackage
`default_nettype wire

// ==== rtl/code_table.sv ====
// Fixed 264 x 9 code table with registered read data
`default_nettype none
`include "kbd_defs.svh"
module code_table (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic [`KBD_ADDR_W-1:0]   addr,
  output logic      [`KBD_CODE_W-1:0]   rd_data
);

  typedef struct packed {
    logic [`KBD_CODE_W-1:0] data;
  } table_state_t;

  table_state_t st;
  table_state_t next_st;

  // Mask-fixed pattern: low byte of the address with even parity on top
  function automatic logic [`KBD_CODE_W-1:0] table_word(input logic [`KBD_ADDR_W-1:0] a);
    logic [7:0] code;
    code = a[7:0];
    return {^code, code};
  endfunction

  always_comb begin
    next_st      = st;
    next_st.data = table_word(addr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.data;

endmodule // code_table
`default_nettype wire

// ==== rtl/debounce_timer.sv ====
// Bounce delay counter that expires after a loaded number of cycles
`default_nettype none
`include "kbd_defs.svh"
module debounce_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start,
  input  wire logic        cancel,
  input  wire logic [15:0] load,
  output logic             expired
);

  typedef struct packed {
    logic        active;
    logic [15:0] count;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  always_comb begin
    next_st = st;
    if (cancel) begin
      next_st.active = 1'b0;
    end else if (start) begin
      // Floor keeps the table read latency covered
      next_st.active = 1'b1;
      next_st.count  = (load < `KBD_DEBOUNCE_MIN) ? `KBD_DEBOUNCE_MIN - 16'h0001
                                                  : load - 16'h0001;
    end else if (st.active && st.count != 16'h0000) begin
      next_st.count = st.count - 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.active && (st.count == 16'h0000);

endmodule // debounce_timer
`default_nettype wire

// ==== tb/key_matrix_model.sv ====
// Switch matrix model: up to two closed keys joining drive to sense
`default_nettype none
module key_matrix_model (
  input  wire logic [7:0]  scan_drive_lines,
  input  wire logic        press_a,
  input  wire logic [2:0]  xa,
  input  wire logic [3:0]  ya,
  input  wire logic        press_b,
  input  wire logic [2:0]  xb,
  input  wire logic [3:0]  yb,
  output logic      [10:0] scan_sense_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open contacts read low: sense inputs are pulled down
  always_comb begin
    scan_sense_lines = 11'h000;
    if (press_a && scan_drive_lines[xa]) scan_sense_lines[ya] = 1'b1;
    if (press_b && scan_drive_lines[xb]) scan_sense_lines[yb] = 1'b1;
  end
endmodule // key_matrix_model
`default_nettype wire

// ==== tb/kbd_checker.sv ====
// Checker of scan, strobe and code relations at the encoder pins
`default_nettype none
module kbd_checker #(
  parameter logic [15:0] DEBOUNCE_CYCLES = 16'h927C
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [7:0]  scan_drive_lines,
  input wire logic [10:0] scan_sense_lines,
  input wire logic [8:0]  key_code_out,
  input wire logic        key_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        wr_pend;
  logic [1:0]  inv;
  logic [1:0]  inv_q;
  logic [5:0]  hold_cnt;
  logic [10:0] sense_q;
  logic        vld;
  // Inversion shadow delayed to the edge at which the pins follow it
  assign vld = key_strobe ^ inv_q[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      inv      <= 2'h0;
      inv_q    <= 2'h0;
      hold_cnt <= 6'h00;
      sense_q  <= 11'h000;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
      if (wr_pend) begin
        inv <= hwdata[1:0];
      end
      inv_q   <= inv;
      sense_q <= scan_sense_lines;
      if (scan_sense_lines != 11'h000 && scan_sense_lines == sense_q) begin
        hold_cnt <= hold_cnt + 6'(hold_cnt != 6'h3F);
      end else begin
        hold_cnt <= 6'h00;
      end
    end
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_quiet;
    (scan_sense_lines == 11'h000) [*8];
  endsequence
  property p_onehot; $onehot(scan_drive_lines); endproperty
  property p_scan; s_quiet |-> ##[0:20] $changed(scan_drive_lines); endproperty
  property p_idle; s_quiet |-> !vld; endproperty
  property p_freeze; hold_cnt >= 6'h10 |-> $stable(scan_drive_lines); endproperty
  property p_keep; hold_cnt >= 6'h1E |-> $stable(key_code_out) && $stable(key_strobe);
  endproperty
  property p_parity; vld |-> key_code_out[8] == (^key_code_out[7:0] ^ inv_q[0]); endproperty
  property p_delay; $rose(vld) |-> 16'(hold_cnt) >= DEBOUNCE_CYCLES; endproperty
  property p_release; vld && scan_sense_lines == 11'h000 |-> ##[0:6] !vld; endproperty
  a_onehot: assert property (p_onehot) else $error("drive ring not one-hot");
  a_scan: assert property (p_scan) else $error("scan stalled");
  a_idle: assert property (p_idle) else $error("strobe valid with no key");
  a_freeze: assert property (p_freeze) else $error("scan moved on match");
  a_keep: assert property (p_keep) else $error("code changed while held");
  a_parity: assert property (p_parity) else $error("parity wrong");
  a_delay: assert property (p_delay) else $error("strobe too early");
  a_release: assert property (p_release) else $error("strobe stuck");
endmodule // kbd_checker
bind keyboard_matrix_encoder kbd_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) kbd_checker_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .scan_drive_lines(scan_drive_lines),
  .scan_sense_lines(scan_sense_lines), .key_code_out(key_code_out), .key_strobe(key_strobe));
`default_nettype wire

// ==== tb/tb_keyboard_matrix_encoder.sv ====
// Testbench of the keyboard matrix encoder
`default_nettype none
module tb_keyboard_matrix_encoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] DEB = 16'h0008;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, xa = 3'h0, xb = 3'h0;
  logic [3:0]  ya = 4'h0, yb = 4'h0;
  logic        shift_key = 1'b0, control_key = 1'b0, press_a = 1'b0, press_b = 1'b0;
  logic        hreadyout, hresp, key_strobe;
  logic [7:0]  drive;
  logic [10:0] sense;
  logic [8:0]  key_code_out;
  int          err_count = 0;
  int          checks = 0;
  always #20 hclk = ~hclk;
  keyboard_matrix_encoder #(.DEBOUNCE_CYCLES(DEB)) keyboard_matrix_encoder_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scan_drive_lines(drive),
    .scan_sense_lines(sense), .shift_key(shift_key), .control_key(control_key),
    .key_code_out(key_code_out), .key_strobe(key_strobe));
  key_matrix_model key_matrix_model_i (.scan_drive_lines(drive), .press_a(press_a),
    .xa(xa), .ya(ya), .press_b(press_b), .xb(xb), .yb(yb), .scan_sense_lines(sense));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic give_up;
    err_count++;
    conclude();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n = 0;
    // Start on a rising edge even when the caller stopped at a falling one
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
    if (n >= 20) give_up();
    r = hrdata;
  endtask
  // Ends at a falling edge so outputs are settled for the caller
  task automatic wait_strobe(input logic lvl, input int lim);
    int n = 0;
    do @(negedge hclk); while (key_strobe !== lvl && ++n < lim);
    if (n >= lim) give_up();
  endtask
  function automatic logic [8:0] code_of(input logic [1:0] g, input logic [2:0] x,
                                         input logic [3:0] y, input logic [1:0] m);
    logic [8:0] a;
    a = 9'(g) * 9'h058 + 9'(x) * 9'h00B + 9'(y);
    return {^a[7:0] ^ m[0], a[7:0] ^ {8{m[1]}}};
  endfunction
  task automatic t_regs;
    logic [31:0] r;
    xfer(1'b0, 32'h0, 32'h0, r);
    check(r, {DEB, 16'h0000});
    xfer(1'b0, 32'h8, 32'h0, r);
    check(r, 32'h0);
    check(hresp, 1'b0);
    xfer(1'b1, 32'h4, 32'hFFFF_FFFF, r);
    xfer(1'b0, 32'h4, 32'h0, r);
    check(r[0], 1'b0);
    $display("test regs done");
  endtask
  // Mode m sets both inversion bits and shift/control levels
  task automatic t_key(input logic [1:0] m, input logic [2:0] x, input logic [3:0] y);
    logic [31:0] r;
    logic [8:0]  e;
    e = code_of(m[1] ? 2'h2 : {1'b0, m[0]}, x, y, m);
    xfer(1'b1, 32'h0, {DEB, 14'h0000, m}, r);
    shift_key <= m[0];
    control_key <= m[1];
    repeat (4) @(negedge hclk);
    check(key_strobe, m[1]);
    @(posedge hclk);
    press_a <= 1'b1;
    xa <= x;
    ya <= y;
    wait_strobe(~m[1], 400);
    check(key_code_out, e);
    repeat (20) @(negedge hclk);
    check(key_code_out, e);
    @(posedge hclk);
    press_a <= 1'b0;
    wait_strobe(m[1], 20);
    check(key_strobe, m[1]);
    $display("test key mode %0d done", m);
  endtask
  task automatic t_bounce;
    logic [31:0] r;
    int n = 0;
    xfer(1'b1, 32'h0, {DEB, 16'h0000}, r);
    shift_key <= 1'b0;
    control_key <= 1'b0;
    press_a <= 1'b1;
    xa <= 3'h2;
    ya <= 4'h0;
    do @(negedge hclk); while (drive[2] !== 1'b1 && ++n < 200);
    if (n >= 200) give_up();
    repeat (3) @(posedge hclk);
    press_a <= 1'b0;
    repeat (30) begin
      @(negedge hclk);
      check(key_strobe, 1'b0);
    end
    $display("test bounce done");
  endtask
  task automatic t_roll;
    @(posedge hclk);
    press_a <= 1'b1;
    xa <= 3'h1;
    ya <= 4'h2;
    wait_strobe(1'b1, 400);
    @(posedge hclk);
    press_b <= 1'b1;
    xb <= 3'h5;
    yb <= 4'h9;
    repeat (40) @(negedge hclk);
    check(key_code_out, code_of(2'h0, 3'h1, 4'h2, 2'h0));
    @(posedge hclk);
    press_a <= 1'b0;
    wait_strobe(1'b0, 20);
    wait_strobe(1'b1, 400);
    check(key_code_out, code_of(2'h0, 3'h5, 4'h9, 2'h0));
    @(posedge hclk);
    press_b <= 1'b0;
    wait_strobe(1'b0, 20);
    $display("test rollover done");
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_key(2'h0, 3'h0, 4'h0);
    t_key(2'h1, 3'h7, 4'hA);
    t_key(2'h2, 3'h3, 4'h5);
    t_key(2'h3, 3'h6, 4'h4);
    t_bounce();
    t_roll();
    conclude();
  end
endmodule // tb_keyboard_matrix_encoder
`default_nettype wire
